/* File: design/state_clocking_front_end.sv */
// Purpose: State-mode acquisition front end with master/slave/demux pods.
// Assumes: Target strobes far slower than i_mclk; all pins asynchronous.
// Notes:   Stored records feed label extraction one cycle later.
`timescale 1ns/1ps
`default_nettype none

module state_clocking_front_end
    import state_front_end_pkg::*;
#(
    parameter int NPOD = ALL_POD,
    parameter int NLAB = LAB_NUM
) (
    // Clock and reset
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst,
    // Target pins
    input  wire logic [NSTROBE-1:0]      i_strobe,
    input  wire logic [NGATE-1:0]        i_gate,
    input  wire logic [ALL_CH-1:0]       i_pod_data,
    // Acquisition control
    input  wire logic                    i_run,
    input  wire logic                    i_restart,
    input  wire arr_type [NPOD-1:0]      i_pod_arr,
    input  wire clk_cond_type            i_master_cond,
    input  wire clk_cond_type            i_slave_cond,
    // Label configuration
    input  wire logic                    i_lab_wr,
    input  wire logic                    i_lab_on_wr,
    input  wire logic                    i_lab_on,
    input  wire logic [$clog2(NLAB)-1:0] i_lab_idx,
    input  wire lab_cfg_type             i_lab_cfg,
    input  wire logic                    i_pair_move,
    input  wire logic [0:0]              i_pair_idx,
    // Stored records
    output logic                         o_store_valid,
    output store_rec_type                o_store,
    // Label results
    output logic                         o_lab_valid,
    output logic [NLAB-1:0][LAB_W-1:0]   o_lab_value,
    output logic [NLAB-1:0]              o_lab_match,
    output logic [NLAB-1:0]              o_lab_on,
    output logic                         o_lab_reject
);

    // Elaboration checks
    if (NPOD != ALL_POD) begin : g_bad_pod
        $error("NPOD must equal the package pod count");
    end
    if (NLAB < 2) begin : g_bad_lab
        $error("NLAB must be at least two");
    end

    // Condition of one clocking arrangement
    function automatic logic cond_match(input clk_cond_type c,
                                        input logic [3:0] r,
                                        input logic [3:0] f,
                                        input logic [3:0] g);
        logic       hit;
        logic [3:0] lvl;
        logic [1:0] use_b;
        logic [1:0] lvl_b;
        logic       edge_any;
        logic       q_and;
        logic       q_or;
        hit = 1'b0;
        lvl = ~(g ^ c.gate_lvl);
        for (int h = 0; h < 2; h++) begin
            edge_any = |((c.rise[2*h +: 2] & r[2*h +: 2])
                       | (c.fall[2*h +: 2] & f[2*h +: 2]));
            use_b = c.gate_use[2*h +: 2];
            lvl_b = lvl[2*h +: 2];
            q_and = &(lvl_b | ~use_b);
            q_or  = (|(lvl_b & use_b)) | ~(|use_b);
            hit = hit | (edge_any & (c.gate_or[h] ? q_or : q_and));
        end
        return hit;
    endfunction : cond_match

    // Number of channels in a mask
    function automatic logic [6:0] popcount(input logic [ALL_CH-1:0] m);
        logic [6:0] cnt;
        cnt = 7'h00;
        for (int i = 0; i < ALL_CH; i++) begin
            cnt = cnt + 7'(m[i]);
        end
        return cnt;
    endfunction : popcount

    // Gather masked channels into consecutive bits from zero
    function automatic logic [LAB_W-1:0] compact(input logic [ALL_CH-1:0] m,
                                                 input logic [ALL_CH-1:0] d);
        logic [LAB_W-1:0] v;
        logic [6:0]       k;
        v = 32'h0000_0000;
        k = 7'h00;
        for (int i = 0; i < ALL_CH; i++) begin
            if (m[i]) begin
                if (k < LAB_MAX_CH) begin
                    v[k[4:0]] = d[i];
                end
                k = k + 7'h01;
            end
        end
        return v;
    endfunction : compact

    // Pin synchronisers
    logic [NSTROBE-1:0] strobe_meta;
    logic [NSTROBE-1:0] strobe_sync;
    logic [NSTROBE-1:0] strobe_prev;
    logic [NGATE-1:0]   gate_meta;
    logic [NGATE-1:0]   gate_sync;
    logic [ALL_CH-1:0]  data_meta;
    logic [ALL_CH-1:0]  data_sync;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            strobe_meta <= '0;
            strobe_sync <= '0;
            strobe_prev <= '0;
            gate_meta   <= '0;
            gate_sync   <= '0;
            data_meta   <= '0;
            data_sync   <= '0;
        end else begin
            strobe_meta <= i_strobe;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
            gate_meta   <= i_gate;
            gate_sync   <= gate_meta;
            data_meta   <= i_pod_data;
            data_sync   <= data_meta;
        end
    end

    // Strobe edges and condition matches
    wire logic [NSTROBE-1:0] rise_w = strobe_sync & ~strobe_prev;
    wire logic [NSTROBE-1:0] fall_w = ~strobe_sync & strobe_prev;
    wire logic master_hit =
        i_run & cond_match(i_master_cond, rise_w, fall_w, gate_sync);
    wire logic slave_hit =
        i_run & cond_match(i_slave_cond, rise_w, fall_w, gate_sync);

    // Pod routing by arrangement
    logic [ALL_CH-1:0] master_sel;
    logic [ALL_CH-1:0] slave_cap;

    always_comb begin
        master_sel = '0;
        slave_cap  = '0;
        for (int p = 0; p < NPOD; p++) begin
            // Odd pod of a demux pair is not sampled on its own
            if (p % 2 == 0 || i_pod_arr[p - p % 2] != ARR_DEMUX) begin
                unique case (i_pod_arr[p])
                    ARR_MASTER: master_sel[p*POD_W +: POD_W] =
                                    data_sync[p*POD_W +: POD_W];
                    ARR_SLAVE:  slave_cap[p*POD_W +: POD_W] =
                                    data_sync[p*POD_W +: POD_W];
                    ARR_DEMUX: begin
                        if (p % 2 == 0) begin
                            master_sel[p*POD_W +: POD_W] =
                                data_sync[p*POD_W +: POD_W];
                            slave_cap[(p+1)*POD_W +: POD_W] =
                                data_sync[p*POD_W +: POD_W];
                        end
                    end
                    ARR_OFF: ;
                endcase
            end
        end
    end

    // Slave holding latch
    logic [ALL_CH-1:0] slave_hold;
    wire logic [ALL_CH-1:0] next_slave =
        i_restart ? '0 : (slave_hit ? slave_cap : slave_hold);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            slave_hold <= '0;
        end else begin
            slave_hold <= next_slave;
        end
    end

    // Record store on master match
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_store_valid <= 1'b0;
            o_store       <= '0;
        end else begin
            o_store_valid <= master_hit;
            if (master_hit) begin
                o_store.master <= master_sel;
                o_store.slave  <= i_restart ? '0 : slave_hold;
            end
        end
    end

    // Label configuration write decode
    wire logic [6:0] wr_cnt = popcount(i_lab_cfg.mask);
    wire logic wr_ok = (wr_cnt != 7'h00) && (wr_cnt <= LAB_MAX_CH);
    logic [ALL_CH-1:0] pair_keep;

    always_comb begin
        pair_keep = '1;
        for (int p = 0; p < NPOD; p++) begin
            if (i_pair_move && (p / 2 == int'(i_pair_idx))) begin
                pair_keep[p*POD_W +: POD_W] = '0;
            end
        end
    end

    // Label configuration store
    logic [ALL_CH-1:0] lab_mask [NLAB];
    logic [LAB_W-1:0]  lab_pat  [NLAB];
    logic [LAB_W-1:0]  lab_care [NLAB];
    logic [NLAB-1:0]   lab_neg;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lab_neg      <= {NLAB{POL_RESET}};
            o_lab_on     <= {NLAB{LAB_ON_RESET}};
            o_lab_reject <= 1'b0;
            for (int l = 0; l < NLAB; l++) begin
                lab_mask[l] <= '0;
                lab_pat[l]  <= '0;
                lab_care[l] <= '0;
            end
        end else begin
            o_lab_reject <= i_lab_wr & ~wr_ok;
            for (int l = 0; l < NLAB; l++) begin
                if (i_lab_wr && wr_ok && int'(i_lab_idx) == l) begin
                    lab_mask[l] <= i_lab_cfg.mask & pair_keep;
                    lab_pat[l]  <= i_lab_cfg.pattern;
                    lab_care[l] <= i_lab_cfg.care;
                    lab_neg[l]  <= i_lab_cfg.neg;
                end else begin
                    lab_mask[l] <= lab_mask[l] & pair_keep;
                end
                if (i_lab_on_wr && int'(i_lab_idx) == l) begin
                    o_lab_on[l] <= i_lab_on;
                end
            end
        end
    end

    // Label extraction and pattern match on the stored record
    logic [LAB_W-1:0] lab_val [NLAB];
    logic [NLAB-1:0]  lab_hit;
    wire logic [ALL_CH-1:0] rec_word = o_store.master | o_store.slave;

    always_comb begin
        for (int l = 0; l < NLAB; l++) begin
            lab_val[l] = compact(lab_mask[l], rec_word)
                       ^ (lab_neg[l] ? compact(lab_mask[l], '1)
                                     : 32'h0000_0000);
            lab_hit[l] = o_lab_on[l] && (((lab_val[l] ^ lab_pat[l])
                       & lab_care[l]) == 32'h0000_0000);
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_lab_valid <= 1'b0;
            o_lab_value <= '0;
            o_lab_match <= '0;
        end else begin
            o_lab_valid <= o_store_valid;
            if (o_store_valid) begin
                for (int l = 0; l < NLAB; l++) begin
                    o_lab_value[l] <= lab_val[l];
                end
                o_lab_match <= lab_hit;
            end
        end
    end

    // Assertion helpers
    logic [ALL_CH-1:0] last_keep;
    logic              pair_left;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            last_keep <= '1;
        end else begin
            last_keep <= pair_keep;
        end
    end
    always_comb begin
        pair_left = 1'b0;
        for (int l = 0; l < NLAB; l++) begin
            pair_left = pair_left | (|(lab_mask[l] & ~last_keep));
        end
    end
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_slave_latch;
        slave_hit && !i_restart;
    endsequence
    sequence s_master_next;
        !slave_hit && !i_restart && master_hit;
    endsequence
    sequence s_two_slaves;
        s_slave_latch ##1 (slave_hit && !master_hit && !i_restart);
    endsequence
    a_master_store: assert property (master_hit |=> o_store_valid)
        else $error("master match did not store a record");
    a_no_idle_store: assert property (!master_hit |=> !o_store_valid)
        else $error("record stored without master match");
    a_master_data: assert property (
        master_hit |=> o_store.master == $past(master_sel))
        else $error("stored master data differs from sampled pods");
    a_slave_pair: assert property (
        s_slave_latch ##1 s_master_next |=>
            o_store.slave == $past(slave_cap, 2))
        else $error("latched slave data not stored with master");
    a_last_slave: assert property (
        s_two_slaves ##1 s_master_next |=>
            o_store.slave == $past(slave_cap, 2))
        else $error("stored slave data is not from the last latch");
    a_restart_clear: assert property (
        i_restart ##1 !slave_hit [*2] |-> slave_hold == '0)
        else $error("slave latch not cleared by restart");
    a_reject_wide: assert property (
        i_lab_wr && !wr_ok && !i_pair_move |=>
            o_lab_reject && lab_mask[$past(i_lab_idx)]
                == $past(lab_mask[i_lab_idx]))
        else $error("oversized label accepted");
    a_disable_keep: assert property (
        i_lab_on_wr && !i_lab_wr && !i_pair_move |=>
            lab_mask[$past(i_lab_idx)] == $past(lab_mask[i_lab_idx]))
        else $error("label toggle changed its channels");
    a_pair_drop: assert property (i_pair_move |=> !pair_left)
        else $error("moved pod pair still assigned to a label");
endmodule : state_clocking_front_end
`default_nettype wire

/* File: design/state_front_end_pkg.sv */
// Purpose: Shared constants and types of the state clocking front end.
// Assumes: Four pods of sixteen channels, four strobes, four gates.
// Notes:   Pods pair up as 0/1 and 2/3; a pair holds 32 channels.
//
// Overview of operation
// - Master pods stored on every master condition match.
// - Slave pods latched, stored with next master.
// - Only the last slave latch before master stored.
// - Demux samples one pod, uses both conditions.
// - Demux slave set latched, stored with master.
// - Four strobe inputs and four gate qualifiers.
// - Edges ORed, gates ANDed, gates ANDed/ORed together.
// - Strobes/gates 1-2 ORed with strobes/gates 3-4.
// - Label takes 1 to 32 channels, else rejected.
// - Label bits numbered from bit zero upward.
// - Split label fields still numbered without gaps.
// - Per-label polarity, positive after reset.
// - Polarity applies to pattern matching.
// - Disabled label keeps its channel assignment.
// - Moved pod pair loses its label assignments.
package state_front_end_pkg;

    // Geometry
    localparam int POD_W      = 16;
    localparam int ALL_POD    = 4;
    localparam int ALL_CH     = 64;
    localparam int PAIR_CH    = 32;
    localparam int LAB_W      = 32;
    localparam int NSTROBE    = 4;
    localparam int NGATE      = 4;
    localparam int LAB_NUM    = 8;
    localparam logic [6:0] LAB_MAX_CH = 7'h20;

    // Reset values
    localparam logic POL_RESET    = 1'b0;
    localparam logic LAB_ON_RESET = 1'b0;

    // Pod clock arrangement
    typedef enum logic [1:0] {
        ARR_MASTER = 2'b00,
        ARR_SLAVE  = 2'b01,
        ARR_DEMUX  = 2'b10,
        ARR_OFF    = 2'b11
    } arr_type;

    // One clocking condition: strobe edges and gate qualifiers
    typedef struct packed {
        logic [NSTROBE-1:0] rise;
        logic [NSTROBE-1:0] fall;
        logic [NGATE-1:0]   gate_use;
        logic [NGATE-1:0]   gate_lvl;
        logic [1:0]         gate_or;
    } clk_cond_type;

    // One label configuration
    typedef struct packed {
        logic [ALL_CH-1:0] mask;
        logic [LAB_W-1:0]  pattern;
        logic [LAB_W-1:0]  care;
        logic              neg;
    } lab_cfg_type;

    // One stored state record
    typedef struct packed {
        logic [ALL_CH-1:0] master;
        logic [ALL_CH-1:0] slave;
    } store_rec_type;

endpackage : state_front_end_pkg

/* File: tb/target_sut.sv */
// Purpose: Model of the target system driving strobes, gates and pods.
// Assumes: Strobe frames of 190 ns; strobe lines rest low between frames.
// Notes:   Pod lines show inverted data once a frame is over.
`timescale 1ns/1ps
`default_nettype none

module target_sut
    import state_front_end_pkg::*;
(
    // Analyzer clock, used only to pace the pins
    input  wire logic              i_mclk,
    // Target pins
    output logic [NSTROBE-1:0]     o_strobe,
    output logic [NGATE-1:0]       o_gate,
    output logic [ALL_CH-1:0]      o_data
);
    // Quiet pins at time zero
    initial begin
        o_strobe = '0;
        o_gate   = '0;
        o_data   = '0;
    end

    // Gate qualifier levels
    task automatic set_gate(input logic [NGATE-1:0] g);
        o_gate = g;
    endtask : set_gate

    // One strobe cycle with data steady around both edges
    task automatic frame(input int idx, input logic [ALL_CH-1:0] d);
        o_data = d;
        repeat (2) @(negedge i_mclk);
        o_strobe[idx] = 1'b1;
        repeat (8) @(negedge i_mclk);
        o_strobe[idx] = 1'b0;
        repeat (8) @(negedge i_mclk);
        o_data = ~d; // Stale data must never be stored
        @(negedge i_mclk);
    endtask : frame

    // Two slave strobes then the master strobe, one cycle apart each
    task automatic burst(input logic [ALL_CH-1:0] d0, d1, d2);
        o_data = d0;
        repeat (2) @(negedge i_mclk);
        o_strobe[1] = 1'b1;
        @(negedge i_mclk);
        o_data      = d1;
        o_strobe[2] = 1'b1;
        @(negedge i_mclk);
        o_data      = d2;
        o_strobe[0] = 1'b1;
        repeat (8) @(negedge i_mclk);
        o_strobe = '0;
        repeat (8) @(negedge i_mclk);
        o_data = ~d2;
        @(negedge i_mclk);
    endtask : burst
endmodule : target_sut
`default_nettype wire

/* File: tb/tb_state_clocking_front_end.sv */
// Purpose: Self-checking bench of the state clocking front end.
// Assumes: Data stable around strobe edges; pins driven at falling edge.
// Notes:   Condition cases run from a table, the rest hand-written.
`timescale 1ns/1ps
`default_nettype none

module tb_state_clocking_front_end
    import state_front_end_pkg::*;
;

    typedef struct {
        clk_cond_type c;
        int           s;
        logic [3:0]   g;
        int           hits;
    } row_type;

    // Stimulus and observed signals
    logic                 i_mclk      = 1'b0;
    logic                 i_rst       = 1'b1;
    wire logic [3:0]      i_strobe;
    wire logic [3:0]      i_gate;
    wire logic [63:0]     i_pod_data;
    logic                 i_run       = 1'b0;
    logic                 i_restart   = 1'b0;
    arr_type [3:0]        i_pod_arr   = {4{ARR_MASTER}};
    clk_cond_type         i_master_cond = '0;
    clk_cond_type         i_slave_cond  = '0;
    logic                 i_lab_wr    = 1'b0;
    logic                 i_lab_on_wr = 1'b0;
    logic                 i_lab_on    = 1'b0;
    logic [2:0]           i_lab_idx   = '0;
    lab_cfg_type          i_lab_cfg   = '0;
    logic                 i_pair_move = 1'b0;
    logic [0:0]           i_pair_idx  = '0;
    logic                 o_store_valid;
    store_rec_type        o_store;
    logic                 o_lab_valid;
    logic [7:0][31:0]     o_lab_value;
    logic [7:0]           o_lab_match;
    logic [7:0]           o_lab_on;
    logic                 o_lab_reject;
    int                   err_count   = 0;
    int                   comparisons = 0;
    int                   stores      = 0;
    int                   labs        = 0;
    int                   base;
    row_type              rows[10];
    localparam logic [63:0] MSK = 64'h0000_0F00_0000_000F;

    always #5 i_mclk = ~i_mclk;

    // Count stored records and label results mid-cycle
    always @(negedge i_mclk) begin
        if (o_store_valid === 1'b1) begin
            stores <= stores + 1;
        end
        if (o_lab_valid === 1'b1) begin
            labs <= labs + 1;
        end
    end

    target_sut far_end (
        .i_mclk   (i_mclk),
        .o_strobe (i_strobe),
        .o_gate   (i_gate),
        .o_data   (i_pod_data)
    );

    state_clocking_front_end uut (
        .i_mclk        (i_mclk),
        .i_rst         (i_rst),
        .i_strobe      (i_strobe),
        .i_gate        (i_gate),
        .i_pod_data    (i_pod_data),
        .i_run         (i_run),
        .i_restart     (i_restart),
        .i_pod_arr     (i_pod_arr),
        .i_master_cond (i_master_cond),
        .i_slave_cond  (i_slave_cond),
        .i_lab_wr      (i_lab_wr),
        .i_lab_on_wr   (i_lab_on_wr),
        .i_lab_on      (i_lab_on),
        .i_lab_idx     (i_lab_idx),
        .i_lab_cfg     (i_lab_cfg),
        .i_pair_move   (i_pair_move),
        .i_pair_idx    (i_pair_idx),
        .o_store_valid (o_store_valid),
        .o_store       (o_store),
        .o_lab_valid   (o_lab_valid),
        .o_lab_value   (o_lab_value),
        .o_lab_match   (o_lab_match),
        .o_lab_on      (o_lab_on),
        .o_lab_reject  (o_lab_reject)
    );

    // Compare one value
    task automatic check(input string n, input logic [63:0] e,
                         input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // Verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    function automatic clk_cond_type cnd(input logic [3:0] r, f, u, l,
                                         input logic [1:0] o);
        return '{rise: r, fall: f, gate_use: u, gate_lvl: l, gate_or: o};
    endfunction : cnd

    // Label write, then look at the refusal flag
    task automatic lab_write(input logic [63:0] m, input logic [31:0] p,
                             input logic n, input logic rej);
        i_lab_cfg = '{mask: m, pattern: p, care: 32'hFF, neg: n};
        i_lab_wr = 1'b1;
        @(negedge i_mclk);
        i_lab_wr = 1'b0;
        check("reject", {63'h0, rej}, {63'h0, o_lab_reject});
        @(negedge i_mclk);
    endtask : lab_write

    task automatic lab_en(input logic on);
        i_lab_on = on;
        i_lab_on_wr = 1'b1;
        @(negedge i_mclk);
        i_lab_on_wr = 1'b0;
        @(negedge i_mclk);
        check("label on", {63'h0, on}, {63'h0, o_lab_on[0]});
    endtask : lab_en

    // Store label 0 from data d and check value and match
    task automatic lab_look(input logic [63:0] d, input logic [31:0] v,
                            input logic mt);
        far_end.frame(0, d);
        check("label value", {32'h0, v}, {32'h0, o_lab_value[0]});
        check("label match", {63'h0, mt}, {63'h0, o_lab_match[0]});
    endtask : lab_look

    // Watchdog
    initial begin
        #50us;
        err_count++;
        results();
    end

    // Main sequence
    initial begin
        rows = '{'{cnd(1, 0, 0, 0, 0), 0, 4'h0, 1},
                 '{cnd(4, 0, 0, 0, 0), 0, 4'h0, 0},
                 '{cnd(1, 0, 1, 1, 0), 0, 4'h0, 0},
                 '{cnd(1, 0, 1, 1, 0), 0, 4'h1, 1},
                 '{cnd(0, 8, 0, 0, 0), 3, 4'h0, 1},
                 '{cnd(1, 0, 4, 4, 0), 0, 4'h0, 1},
                 '{cnd(1, 0, 3, 3, 1), 0, 4'h1, 1},
                 '{cnd(1, 0, 3, 3, 0), 0, 4'h1, 0},
                 '{cnd(3, 0, 0, 0, 0), 1, 4'h0, 1},
                 '{cnd(1, 1, 0, 0, 0), 0, 4'h0, 2}};
        repeat (16) @(negedge i_mclk);
        check("store valid in reset", 64'h0, {63'h0, o_store_valid});
        check("labels on in reset", 64'h0, {56'h0, o_lab_on});
        $display("test reset done");
        i_rst = 1'b0;
        i_run = 1'b1;
        @(negedge i_mclk);
        // Clocking conditions from the table
        foreach (rows[i]) begin
            i_master_cond = rows[i].c;
            far_end.set_gate(rows[i].g);
            base = stores;
            far_end.frame(rows[i].s, 64'h0123_4567_89AB_CDEF ^ 64'(i));
            check("store count", 64'(rows[i].hits), 64'(stores - base));
            if (rows[i].hits > 0) begin
                check("master data", 64'h0123_4567_89AB_CDEF ^ 64'(i), o_store.master);
            end
        end
        $display("test conditions done");
        // Slave pods: last latch before master is stored
        far_end.set_gate(4'h0);
        i_master_cond = cnd(1, 0, 0, 0, 0);
        i_slave_cond = cnd(6, 0, 0, 0, 0);
        i_pod_arr = {ARR_SLAVE, ARR_SLAVE, ARR_MASTER, ARR_MASTER};
        base = stores;
        far_end.frame(1, 64'h1111_2222_3333_4444);
        far_end.frame(1, 64'h5555_6666_7777_8888);
        far_end.frame(0, 64'h9999_AAAA_BBBB_CCCC);
        check("slave store count", 64'h1, 64'(stores - base));
        check("master half", 64'hBBBB_CCCC, {32'h0, o_store.master[31:0]});
        check("slave half", 64'h5555_6666, {32'h0, o_store.slave[63:32]});
        // Slave, slave, master on consecutive cycles
        base = stores;
        far_end.burst(64'h0101_0101_0000_0000, 64'h0202_0202_0000_0000,
                      64'h0000_0000_0303_0303);
        check("burst count", 64'h1, 64'(stores - base));
        check("burst master", 64'h0303_0303,
              {32'h0, o_store.master[31:0]});
        check("burst slave", 64'h0202_0202,
              {32'h0, o_store.slave[63:32]});
        // Restart drops the held slave data
        far_end.frame(1, 64'h1234_5678_0000_0000);
        i_restart = 1'b1;
        @(negedge i_mclk);
        i_restart = 1'b0;
        far_end.frame(0, 64'h0);
        check("slave after restart", 64'h0, {32'h0, o_store.slave[63:32]});
        $display("test slave done");
        // Demultiplex on pod 0
        i_pod_arr = {ARR_OFF, ARR_OFF, ARR_SLAVE, ARR_DEMUX};
        far_end.frame(1, 64'h0000_0000_0000_1357);
        far_end.frame(1, 64'h0000_0000_0000_2468);
        far_end.frame(0, 64'h0000_0000_0000_ACE1);
        check("demux master", 64'hACE1, {48'h0, o_store.master[15:0]});
        check("demux slave", 64'h2468, {48'h0, o_store.slave[31:16]});
        $display("test demux done");
        // Labels: split fields, polarity, enable, refusal, pair move
        i_pod_arr = {4{ARR_MASTER}};
        lab_write(MSK, 32'h0A, 1'b0, 1'b0);
        lab_en(1'b1);
        lab_look(64'hA, 32'h0A, 1'b1);
        lab_write(MSK, 32'hF5, 1'b1, 1'b0);
        lab_look(64'hA, 32'hF5, 1'b1);
        lab_en(1'b0);
        lab_look(64'hA, 32'hF5, 1'b0);
        lab_en(1'b1);
        lab_write({31'h0, 33'h1_FFFF_FFFF}, 32'h0, 1'b0, 1'b1);
        lab_write(64'h0, 32'h0, 1'b0, 1'b1);
        lab_look(64'hA, 32'hF5, 1'b1);
        i_lab_idx = 3'h1;
        lab_write(64'hFFFF_FFFF, 32'h0, 1'b0, 1'b0);
        i_lab_idx = 3'h0;
        i_pair_idx = 1'b1;
        i_pair_move = 1'b1;
        @(negedge i_mclk);
        i_pair_move = 1'b0;
        lab_look(64'h0000_0500_0000_000A, 32'h5, 1'b0);
        check("label records", 64'(stores), 64'(labs));
        $display("test labels done");
        results();
    end
endmodule : tb_state_clocking_front_end
`default_nettype wire
